// ### dvitx_top.sv
/*
 DVI transmit line encoder: input capture, channel mapping, coding.
 Assumes pixel inputs synchronous to pixel_input_clock and a
 serialiser outside that shifts each 10-bit character out LSB first.
*/
`timescale 1ns/1ps
module dvitx_top import dvitx_pkg::*; (
    input wire logic aclk, // Register clock
    input wire logic aresetn, // Sync reset, low
    input wire logic [31:0] awaddr, // Write address
    input wire logic awvalid, // Write address valid
    output logic awready, // Write address ready
    input wire logic [31:0] wdata, // Write data
    input wire logic [3:0] wstrb, // Write strobes
    input wire logic wvalid, // Write data valid
    output logic wready, // Write data ready
    output logic [1:0] bresp, // Write response
    output logic bvalid, // Write response valid
    input wire logic bready, // Write response ready
    input wire logic [31:0] araddr, // Read address
    input wire logic arvalid, // Read address valid
    output logic arready, // Read address ready
    output logic [31:0] rdata, // Read data
    output logic [1:0] rresp, // Read response
    output logic rvalid, // Read data valid
    input wire logic rready, // Read data ready
    input wire logic pixel_input_clock, // Pixel clock
    input wire logic [23:0] pixel_data, // Pixel lines
    input wire logic active_video_flag, // High in active video
    input wire logic hsync, // Horizontal sync
    input wire logic vsync, // Vertical sync
    input wire logic [2:1] blanking_control_bits, // Reserved ctl
    input wire logic protect_ctl3, // Ctl3 from cipher
    input wire logic strap_bus_width, // Strap width select
    input wire logic strap_latch_edge, // Strap latch edge
    output logic [9:0] link_pair_red, // Channel 2 char
    output logic [9:0] link_pair_green, // Channel 1 char
    output logic [9:0] link_pair_blue, // Channel 0 char
    output logic [9:0] link_clock_pair, // Clock char
    output logic deskew_enable, // Pad delay enable
    output logic [2:0] deskew_setting // Pad delay code
);
    // ------------------------------------------------
    // Register side
    // ------------------------------------------------
    logic [CFG_W-1:0] cfg, next_cfg; // Config register
    logic [1:0] st_meta, st_sync; // Straps sync
    logic [1:0] strap, next_strap; // Captured straps
    logic strap_done, next_strap_done; // Capture taken
    logic av_meta, av_sync; // Active video to aclk
    logic aw_ok, next_aw_ok, w_ok, next_w_ok; // Halves held
    logic [31:0] aw_q, next_aw_q, w_q, next_w_q; // Held payload
    logic [3:0] ws_q, next_ws_q; // Held strobes
    logic next_awready, next_wready, next_bvalid, next_arready;
    logic next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic [1:0] eff, next_eff; // Effective width, edge
    logic next_trim_en;
    logic [2:0] next_trim;

    // Bus decode and config update
    always_comb begin
        next_aw_ok = aw_ok;
        next_w_ok = w_ok;
        next_aw_q = aw_q;
        next_w_q = w_q;
        next_ws_q = ws_q;
        next_cfg = cfg;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        next_strap = strap;
        next_strap_done = 1'b1;
        if (!strap_done) begin // Catch straps after release
            next_strap = st_sync;
        end
        if (awvalid && awready) begin
            next_aw_ok = 1'b1;
            next_aw_q = awaddr;
        end
        if (wvalid && wready) begin
            next_w_ok = 1'b1;
            next_w_q = wdata;
            next_ws_q = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_ok && w_ok && !bvalid) begin // Both halves in
            next_aw_ok = 1'b0;
            next_w_ok = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = RESP_SLVERR;
            if (aw_q[31:2] == REG_CONFIG[31:2]) begin
                next_bresp = RESP_OKAY;
                if (ws_q[0]) begin
                    next_cfg = w_q[CFG_W-1:0];
                end
            end else if (aw_q[31:2] == REG_STATUS[31:2] ||
                         aw_q[31:2] == REG_STRAP[31:2]) begin
                next_bresp = RESP_OKAY; // Read-only, write dropped
            end
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin // Read answer next cycle
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (araddr[31:2] == REG_CONFIG[31:2]) begin
                next_rdata[CFG_W-1:0] = cfg;
            end else if (araddr[31:2] == REG_STATUS[31:2]) begin
                next_rdata[2:0] = {eff, av_sync};
            end else if (araddr[31:2] == REG_STRAP[31:2]) begin
                next_rdata[1:0] = strap;
            end else begin
                next_rresp = RESP_SLVERR;
            end
        end
        next_awready = !next_aw_ok && !next_bvalid;
        next_wready = !next_w_ok && !next_bvalid;
        next_arready = !next_rvalid;
        // Serial config overrides straps
        next_eff = next_cfg[CFG_SCE] ? {next_cfg[CFG_BW], next_cfg[CFG_EDGE]}
                                     : next_strap;
        next_trim_en = next_cfg[CFG_TRIM_EN]; // Trim steps of DESKEW_STEP_PS
        next_trim = next_cfg[CFG_TRIM_HI:CFG_TRIM_LO];
    end

    // Register side flops
    always_ff @(posedge aclk) begin
        st_meta <= {strap_bus_width, strap_latch_edge};
        st_sync <= st_meta;
        av_meta <= active_video_flag;
        av_sync <= av_meta;
        if (!aresetn) begin
            cfg <= CFG_RESET;
            strap <= 2'h0;
            strap_done <= 1'b0;
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            aw_q <= 32'h0000_0000;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
            eff <= 2'h0;
            deskew_enable <= 1'b0;
            deskew_setting <= 3'h0;
        end else begin
            cfg <= next_cfg;
            strap <= next_strap;
            strap_done <= next_strap_done;
            aw_ok <= next_aw_ok;
            w_ok <= next_w_ok;
            aw_q <= next_aw_q;
            w_q <= next_w_q;
            ws_q <= next_ws_q;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
            eff <= next_eff;
            deskew_enable <= next_trim_en;
            deskew_setting <= next_trim;
        end
    end

    // ------------------------------------------------
    // Pixel side: capture and mapping
    // ------------------------------------------------
    logic pr_meta, pr_sync; // Reset into pixel domain
    logic [1:0] md_meta, md_sync; // Width, edge into pixel domain
    logic [29:0] r_q, f_q; // Rising and falling samples
    logic [29:0] next_prim; // Primary sample, controls aligned with data
    logic [23:0] s_word, next_word; // Assembled pixel
    logic s_act, s_hs, s_vs; // Staged flags
    logic [3:1] s_ctl; // Staged control bits

    // Falling-edge sample of all inputs
    always_ff @(negedge pixel_input_clock) begin
        f_q <= {active_video_flag, hsync, vsync, protect_ctl3, blanking_control_bits,
                pixel_data};
    end

    // Pick the sample pair by width and edge
    always_comb begin
        next_prim = md_sync[0] ? r_q : f_q;
        if (md_sync[1]) begin // 24-bit single edge
            next_word = next_prim[23:0];
        end else if (md_sync[0]) begin // Rising first, falling second
            next_word = {f_q[11:0], r_q[11:0]};
        end else begin // Falling first, rising second
            next_word = {pixel_data[11:0], f_q[11:0]};
        end
    end

    // Pixel stage flops, one pixel per clock
    always_ff @(posedge pixel_input_clock) begin
        pr_meta <= aresetn;
        pr_sync <= pr_meta;
        md_meta <= eff;
        md_sync <= md_meta;
        r_q <= {active_video_flag, hsync, vsync, protect_ctl3, blanking_control_bits,
                pixel_data};
        if (!pr_sync) begin
            s_word <= 24'h00_0000;
            s_act <= 1'b0;
            {s_hs, s_vs, s_ctl} <= 5'h00;
        end else begin
            s_word <= next_word;
            s_act <= next_prim[29];
            s_hs <= next_prim[28];
            s_vs <= next_prim[27];
            // Ctl3 from cipher input, ctl2:1 passed as is
            s_ctl <= next_prim[26:24];
        end
    end

    // ------------------------------------------------
    // Per-channel coding
    // ------------------------------------------------
    logic [7:0] ch_dat [3]; // Colour byte per channel
    logic [1:0] ch_ctl [3]; // Control pair per channel
    logic [9:0] ch_chr [3]; // Character per channel
    logic signed [5:0] ch_cnt [3]; // Running tally

    assign ch_dat[2] = s_word[23:16]; // Red
    assign ch_dat[1] = s_word[15:8]; // Green
    assign ch_dat[0] = s_word[7:0]; // Blue
    assign ch_ctl[2] = s_ctl[3:2];
    assign ch_ctl[1] = {s_ctl[1], 1'b0};
    assign ch_ctl[0] = {s_vs, s_hs};

    for (genvar c = 0; c < 3; c++) begin : g_ch
        logic [9:0] next_chr;
        logic signed [5:0] next_cnt;
        logic [8:0] qm;
        logic [3:0] n1, nq;
        logic signed [5:0] dq;

        // Transition-minimised, DC-balanced coding
        always_comb begin
            n1 = 4'h0;
            nq = 4'h0;
            for (int b = 0; b < 8; b++) begin
                n1 = n1 + {3'h0, ch_dat[c][b]};
            end
            qm[0] = ch_dat[c][0];
            for (int b = 1; b < 8; b++) begin
                qm[b] = (n1 > HALF_ONES || (n1 == HALF_ONES && !ch_dat[c][0]))
                      ? ~(qm[b-1] ^ ch_dat[c][b]) : (qm[b-1] ^ ch_dat[c][b]);
            end
            qm[8] = !(n1 > HALF_ONES || (n1 == HALF_ONES && !ch_dat[c][0]));
            for (int b = 0; b < 8; b++) begin
                nq = nq + {3'h0, qm[b]};
            end
            dq = $signed({1'b0, nq, 1'b0}) - DISP_MID;
            if (!s_act) begin // Blanking: fixed token, tally cleared
                next_cnt = DISP_ZERO;
                unique case (ch_ctl[c])
                    2'h0: next_chr = TOK_00;
                    2'h1: next_chr = TOK_01;
                    2'h2: next_chr = TOK_10;
                    2'h3: next_chr = TOK_11;
                endcase
            end else if (ch_cnt[c] == DISP_ZERO || dq == DISP_ZERO) begin
                next_chr = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
                next_cnt = qm[8] ? ch_cnt[c] + dq : ch_cnt[c] - dq;
            end else if ((ch_cnt[c] > DISP_ZERO && dq > DISP_ZERO) ||
                         (ch_cnt[c] < DISP_ZERO && dq < DISP_ZERO)) begin
                next_chr = {1'b1, qm[8], ~qm[7:0]};
                next_cnt = ch_cnt[c] + (qm[8] ? DISP_STEP : DISP_ZERO) - dq;
            end else begin
                next_chr = {1'b0, qm[8], qm[7:0]};
                next_cnt = ch_cnt[c] - (qm[8] ? DISP_ZERO : DISP_STEP) + dq;
            end
        end

        // Character and tally flops
        always_ff @(posedge pixel_input_clock) begin
            if (!pr_sync) begin
                ch_chr[c] <= TOK_00;
                ch_cnt[c] <= DISP_ZERO;
            end else begin
                ch_chr[c] <= next_chr;
                ch_cnt[c] <= next_cnt;
            end
        end

        a_tally_even: assert property (@(posedge pixel_input_clock)
            disable iff (!pr_sync) ch_cnt[c][0] == 1'b0)
            else $error("tally went odd");
    end

    // Three encoded channels and clock pattern out
    assign link_pair_red = ch_chr[2];
    assign link_pair_green = ch_chr[1];
    assign link_pair_blue = ch_chr[0];
    assign link_clock_pair = CLK_CHAR;

    // ------------------------------------------------
    // Checks
    // ------------------------------------------------
    a_blank_token: assert property (@(posedge pixel_input_clock) disable iff (!pr_sync)
        !s_act && s_vs && !s_hs |=> link_pair_blue == TOK_10)
        else $error("sync token wrong");
    a_blank_clear: assert property (@(posedge pixel_input_clock) disable iff (!pr_sync)
        !s_act |=> ch_cnt[1] == DISP_ZERO)
        else $error("tally not cleared in blanking");
    a_data_char: assert property (@(posedge pixel_input_clock) disable iff (!pr_sync)
        s_act |=> link_pair_red != TOK_00 && link_pair_red != TOK_11)
        else $error("control token in active video");
    a_ctl3_route: assert property (@(posedge pixel_input_clock) disable iff (!pr_sync)
        !s_act && s_ctl[3] && s_ctl[2] |=> link_pair_red == TOK_11)
        else $error("ctl3 not on red channel");
    a_cfg_write: assert property (@(posedge aclk) disable iff (!aresetn)
        aw_ok && w_ok && !bvalid && aw_q == REG_CONFIG && ws_q[0]
        |=> cfg == $past(w_q[CFG_W-1:0]) && bvalid && bresp == RESP_OKAY)
        else $error("config write lost");
    a_bad_read: assert property (@(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr[31:4] != 28'h000_0000
        |=> rvalid && rresp == RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    a_override: assert property (@(posedge aclk) disable iff (!aresetn)
        cfg[CFG_SCE] |-> eff == {cfg[CFG_BW], cfg[CFG_EDGE]})
        else $error("override not applied");
    a_deskew_out: assert property (@(posedge aclk) disable iff (!aresetn)
        deskew_enable == cfg[CFG_TRIM_EN] || $changed(cfg))
        else $error("deskew enable stale");

    c_video_start: cover property (@(posedge pixel_input_clock) $rose(s_act));
    c_dual_edge: cover property (@(posedge pixel_input_clock) s_act && !md_sync[1]);
    c_cfg_write: cover property (@(posedge aclk) bvalid && bready);
    c_status_read: cover property (@(posedge aclk) rvalid && rready && rdata[0]);
endmodule : dvitx_top

// ### dvitx_pkg.sv
/*
 Constants for the DVI link encoder: register map, fields, tokens.
 Assumes a 32-bit AXI4-Lite register bus.
*/
package dvitx_pkg;
    // ------------------------------------------------
    // Register map
    // ------------------------------------------------
    localparam logic [31:0] REG_CONFIG = 32'h0000_0000; // Rw config
    localparam logic [31:0] REG_STATUS = 32'h0000_0004; // Ro live state
    localparam logic [31:0] REG_STRAP = 32'h0000_0008; // Ro strap levels
    localparam int CFG_W = 7; // Config width
    localparam int CFG_BW = 0; // Bus width select
    localparam int CFG_EDGE = 1; // Latch edge
    localparam int CFG_TRIM_EN = 2; // Deskew enable
    localparam int CFG_TRIM_LO = 3; // Deskew setting low
    localparam int CFG_TRIM_HI = 5; // Deskew setting high
    localparam int CFG_SCE = 6; // Serial config enable
    localparam logic [CFG_W-1:0] CFG_RESET = 7'h00; // Config reset
    localparam logic [1:0] RESP_OKAY = 2'h0; // AXI okay
    localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI slave error
    // ------------------------------------------------
    // Line coding
    // ------------------------------------------------
    localparam int DESKEW_STEP_PS = 350; // Trim step of pad delay
    localparam logic [9:0] TOK_00 = 10'h354; // Control pair 00
    localparam logic [9:0] TOK_01 = 10'h0AB; // Control pair 01
    localparam logic [9:0] TOK_10 = 10'h154; // Control pair 10
    localparam logic [9:0] TOK_11 = 10'h2AB; // Control pair 11
    localparam logic [9:0] CLK_CHAR = 10'h3E0; // Link clock pattern
    localparam logic [3:0] HALF_ONES = 4'h4; // Half of a byte
    localparam logic signed [5:0] DISP_STEP = 6'sh02; // Qm8 weight
    localparam logic signed [5:0] DISP_MID = 6'sh08; // Byte bit count
    localparam logic signed [5:0] DISP_ZERO = 6'sh00; // Balanced tally
endpackage : dvitx_pkg

// ### dvitx_gfx_model.sv
/*
 Graphics controller model: drives one pixel per pixel clock.
 Assumes the caller invokes drive once per pixel, back to back.
*/
`timescale 1ns/1ps
module dvitx_gfx_model (
    input wire logic pixel_input_clock, // Pixel clock
    output logic [23:0] pixel_data, // Pixel lines
    output logic active_video_flag, // Active video
    output logic hsync, // Horizontal sync
    output logic vsync, // Vertical sync
    output logic [2:1] blanking_control_bits, // Reserved ctl
    output logic protect_ctl3 // Ctl3 from cipher
);
    // Idle levels at time zero
    initial begin
        pixel_data = 24'h000000;
        active_video_flag = 1'b0;
        hsync = 1'b0;
        vsync = 1'b0;
        blanking_control_bits = 2'h0;
        protect_ctl3 = 1'b0;
    end

    // One pixel on all 24 lines per rising edge
    task automatic drive(input logic act, input logic [23:0] d, input logic hs,
                         input logic vs, input logic [2:1] c21, input logic c3);
        @(posedge pixel_input_clock);
        pixel_data <= d;
        active_video_flag <= act;
        // Controls change only in blanking
        if (!act) begin
            hsync <= hs;
            vsync <= vs;
            blanking_control_bits <= c21;
            protect_ctl3 <= c3;
        end
    endtask : drive
endmodule : dvitx_gfx_model

// ### dvi_tmds_link_encoder_test.sv
/*
 Self-checking bench: register access and pixel coding.
 Assumes the pixel model and a reference coder kept here.
*/
`timescale 1ns/1ps
module dvi_tmds_link_encoder_test;
    import dvitx_pkg::*;
    typedef struct {int stamp; logic [9:0] r, g, b;} dvitx_note_s; // Expected chars
    // ------------------------------------------------
    // Signals
    // ------------------------------------------------
    logic aclk = 0, aresetn = 0, pixel_input_clock = 0; // Clocks, reset
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata; // Bus payload
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0; // Bus strobes
    logic awready, wready, bvalid, arready, rvalid; // Bus answers
    logic [3:0] wstrb = 4'hF; // Strobes
    logic [1:0] bresp, rresp, resp; // Responses
    logic [23:0] pixel_data; // Pixel lines
    logic active_video_flag, hsync, vsync, protect_ctl3; // Pixel controls
    logic [2:1] blanking_control_bits; // Reserved ctl
    logic strap_bus_width = 1, strap_latch_edge = 1; // Straps: 24 bit, rising
    logic [9:0] link_pair_red, link_pair_green, link_pair_blue, link_clock_pair; // Chars
    logic deskew_enable; // Pad delay enable
    logic [2:0] deskew_setting; // Pad delay code
    logic [31:0] rd, v; // Scratch
    int n_mismatch = 0, n_checks = 0, pcyc = 0, tcount = 0, cr = 0, cg = 0, cb = 0;
    dvitx_note_s notes[$]; // Pending expectations
    dvitx_note_s wn; // Note under compare

    // Register clock and unrelated pixel clock
    initial forever #5 aclk = ~aclk;
    initial begin
        #37;
        forever #62.5 pixel_input_clock = ~pixel_input_clock;
    end
    always @(posedge pixel_input_clock) pcyc <= pcyc + 1;

    dvitx_gfx_model gfx (.pixel_input_clock(pixel_input_clock), .pixel_data(pixel_data),
        .active_video_flag(active_video_flag), .hsync(hsync), .vsync(vsync),
        .blanking_control_bits(blanking_control_bits), .protect_ctl3(protect_ctl3));
    dvitx_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .pixel_input_clock(pixel_input_clock),
        .pixel_data(pixel_data), .active_video_flag(active_video_flag), .hsync(hsync),
        .vsync(vsync), .blanking_control_bits(blanking_control_bits),
        .protect_ctl3(protect_ctl3), .strap_bus_width(strap_bus_width),
        .strap_latch_edge(strap_latch_edge), .link_pair_red(link_pair_red),
        .link_pair_green(link_pair_green), .link_pair_blue(link_pair_blue),
        .link_clock_pair(link_clock_pair), .deskew_enable(deskew_enable),
        .deskew_setting(deskew_setting));
    // ------------------------------------------------
    // Compare and report
    // ------------------------------------------------
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected reg at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_reg
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected resp at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_resp
    task automatic check_char(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected char at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : check_char
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    // Hang guard, far above the expected run length
    always @(posedge aclk) begin
        tcount++;
        if (tcount == 20000) begin
            n_mismatch++;
            final_report;
        end
    end
    // ------------------------------------------------
    // Register bus master
    // ------------------------------------------------
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw_done = 1;
                awvalid <= 0;
            end
            if (wvalid && wready === 1'b1) begin
                w_done = 1;
                wvalid <= 0;
            end
        end
        bready <= 1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask : axi_write
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 0;
        rready <= 1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask : axi_read
    // ------------------------------------------------
    // Reference coder and pixel driver
    // ------------------------------------------------
    function automatic logic [9:0] tmds(input logic [7:0] d, inout int cnt);
        logic [8:0] qm;
        logic xn;
        int nq;
        xn = ($countones(d) > 4) || ($countones(d) == 4 && !d[0]);
        qm[0] = d[0];
        for (int i = 1; i < 8; i++) qm[i] = xn ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
        qm[8] = !xn;
        nq = $countones(qm[7:0]);
        if (cnt == 0 || nq == 4) begin
            tmds = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
            cnt += qm[8] ? (2 * nq - 8) : (8 - 2 * nq);
        end else if ((cnt > 0 && nq > 4) || (cnt < 0 && nq < 4)) begin
            tmds = {1'b1, qm[8], ~qm[7:0]};
            cnt += 2 * qm[8] + (8 - 2 * nq);
        end else begin
            tmds = {1'b0, qm[8], qm[7:0]};
            cnt += -2 * (!qm[8]) + (2 * nq - 8);
        end
    endfunction : tmds
    function automatic logic [9:0] tok(input logic [1:0] p);
        return (p == 2'h0) ? TOK_00 : (p == 2'h1) ? TOK_01 : (p == 2'h2) ? TOK_10 : TOK_11;
    endfunction : tok
    // Drive one pixel and note its three characters
    task automatic pix(input logic act, input logic [23:0] d, input logic [3:0] c);
        dvitx_note_s n;
        gfx.drive(act, d, c[0], c[1], c[3:2], c[1] ^ c[2]);
        if (act) begin
            n.r = tmds(d[23:16], cr);
            n.g = tmds(d[15:8], cg);
            n.b = tmds(d[7:0], cb);
        end else begin
            {cr, cg, cb} = '0;
            n.r = tok({c[1] ^ c[2], c[3]});
            n.g = tok({c[2], 1'b0});
            n.b = tok({c[1], c[0]});
        end
        n.stamp = pcyc + 4; // Pins, sample, stage, character
        notes.push_back(n);
    endtask : pix
    // Watcher: oldest note against outputs when its character is due
    always @(negedge pixel_input_clock) begin
        if (notes.size() > 0 && notes[0].stamp == pcyc) begin
            wn = notes.pop_front();
            check_char(link_pair_red, wn.r);
            check_char(link_pair_green, wn.g);
            check_char(link_pair_blue, wn.b);
            check_char(link_clock_pair, CLK_CHAR);
        end
    end
    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        void'($urandom(20));
        repeat (8) @(posedge pixel_input_clock);
        @(posedge aclk) aresetn <= 1;
        repeat (2) @(posedge aclk);
        axi_read(REG_CONFIG, rd, resp);
        check_reg(rd, 32'h0);
        axi_read(REG_STRAP, rd, resp);
        check_reg(rd, 32'h3);
        axi_read(REG_STATUS, rd, resp);
        check_reg(rd, 32'h6);
        for (int k = 0; k < 4; k++) begin
            v = {25'h0, 1'b1, 3'($urandom), 1'(k), 2'h3};
            axi_write(REG_CONFIG, v, 4'hF, resp);
            check_resp(resp, RESP_OKAY);
            check_reg({28'h0, deskew_setting, deskew_enable}, {28'h0, v[5:2]});
        end
        axi_write(REG_CONFIG, $urandom, 4'h0, resp);
        axi_read(REG_CONFIG, rd, resp);
        check_reg(rd, v);
        axi_write(REG_STRAP, 32'h0, 4'hF, resp);
        axi_read(REG_STRAP, rd, resp);
        check_reg(rd, 32'h3);
        axi_write(32'h10, 32'h1, 4'hF, resp);
        check_resp(resp, RESP_SLVERR);
        axi_read(32'h10, rd, resp);
        check_resp(resp, RESP_SLVERR);
        check_reg(rd, 32'h0);
        $display("register test done");
        for (int f = 0; f < 3; f++) begin
            for (int i = 0; i < 20; i++) pix(0, 24'($urandom), 4'($urandom));
            pix(1, 24'h000000, 4'($urandom));
            pix(1, 24'hFFFFFF, 4'($urandom));
            for (int i = 0; i < 38; i++) pix(1, 24'($urandom), 4'($urandom));
        end
        for (int i = 0; i < 10; i++) pix(0, 24'($urandom), 4'($urandom));
        repeat (8) @(posedge pixel_input_clock);
        check_reg(32'(notes.size()), 32'h0);
        $display("pixel test done");
        final_report;
    end
endmodule : dvi_tmds_link_encoder_test
